// ---- common/icct_defines.svh ----
// register offsets, field positions and reset values of the capture/compare timer
`ifndef ICCT_DEFINES_SVH
`define ICCT_DEFINES_SVH

`define OFS_CTRL        8'h00
`define OFS_CAP_CTL0    8'h04
`define OFS_CAP_CTL1    8'h08
`define OFS_FRC         8'h0C
`define OFS_CAP0        8'h10
`define OFS_CAP5        8'h24
`define OFS_CMP0        8'h28
`define OFS_CMP1        8'h2C
`define OFS_MUX         8'h30

`define BIT_TURN_ON     0
`define BIT_TCS_LO      4
`define BIT_CMP_EN0     8
`define BIT_SET0        17
`define BIT_CLR0        25

`define CAP_FIELD_W     8
`define MUX_FIELD_W     4
`define FILT_TICKS      2'h3
`define DIV_W           7
`define RST_EDGE        2'h3
`define RST_MUX         24'h543210

`endif

// ---- common/icct_pkg.sv ----
// types shared by the capture/compare timer modules
package icct_pkg;

    typedef enum logic [1:0] {
        EDGE_FALL = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_BOTH = 2'h2,
        EDGE_OFF  = 2'h3
    } edge_type;

    typedef struct packed {
        logic     bypass;
        edge_type edge_mode;
    } cap_cfg_type;

    typedef struct packed {
        logic [1:0] cmp;
        logic [5:0] cap;
        logic       ovf;
    } event_type;

endpackage

// ---- rtl/capture_channel.sv ----
// one capture channel: noise filter, edge detector and capture register
`timescale 1ns/1ps
`default_nettype none
`include "icct_defines.svh"

module capture_channel
    import icct_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        active,
    input  wire logic        pin_sync,
    input  wire logic        filt_tick,
    input  wire cap_cfg_type cfg,
    input  wire logic [31:0] frc,
    output logic      [31:0] cap_r,
    output logic             fire_r
);
    logic [1:0] filt_cnt_r;
    logic       filt_r;
    logic       level;
    logic       level_prev_r;
    logic       fire;

    // filtered level moves only after three agreeing filter ticks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            filt_cnt_r <= 2'h0;
            filt_r     <= 1'b0;
        end else if (clk_en && filt_tick) begin
            if (pin_sync == filt_r) begin
                filt_cnt_r <= 2'h0;
            end else if (filt_cnt_r == `FILT_TICKS - 2'h1) begin
                filt_r     <= pin_sync;
                filt_cnt_r <= 2'h0;
            end else begin
                filt_cnt_r <= filt_cnt_r + 2'h1;
            end
        end
    end

    assign level = cfg.bypass ? pin_sync : filt_r;

    // edge selection
    always_comb begin
        fire = 1'b0;
        unique case (cfg.edge_mode)
            EDGE_FALL: fire = level_prev_r & ~level;
            EDGE_RISE: fire = ~level_prev_r & level;
            EDGE_BOTH: fire = level_prev_r ^ level;
            EDGE_OFF:  fire = 1'b0;
        endcase
        fire = fire & active;
    end

    // capture register and its event, overwritten at every edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            level_prev_r <= 1'b0;
            cap_r        <= 32'h0000_0000;
            fire_r       <= 1'b0;
        end else if (clk_en) begin
            level_prev_r <= level;
            fire_r       <= fire;
            if (fire) begin
                cap_r <= frc;
            end
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_cap_takes_count: assert property (clk_en && fire |=> fire_r && cap_r == $past(frc))
        else $error("capture missed counter value");
    a_filter_three_ticks: assert property (
        clk_en && !$changed(cfg) && $changed(filt_r) |-> $past(filt_tick)
            && $past(filt_cnt_r) == 2'h2)
        else $error("filter moved early");
    a_cap_only_on_edge: assert property (clk_en && !fire |=> $stable(cap_r) && !fire_r)
        else $error("capture changed without edge");
    c_capture: cover property (fire_r);

endmodule // capture_channel
`default_nettype wire

// ---- rtl/input_capture_compare_timer.sv ----
// free-running counter with six capture and two compare channels
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "icct_defines.svh"


module input_capture_compare_timer
    import icct_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       clk_en,
    input  wire logic [7:0] addr,
    input  wire logic [31:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [31:0] rdata_r,
    input  wire logic [5:0] capture_input_pin,
    input  wire logic       noise_filter_clock,
    input  wire logic       sleep_en,
    input  wire logic       low_power_req,
    output logic            low_power_ack_r,
    output logic            compare_output_pin_0,
    output logic            compare_output_pin_1,
    output event_type       events_r
);
    logic        turn_on_r;
    logic [2:0]  tcs_r;
    logic [1:0]  cmp_en_r;
    cap_cfg_type cap_cfg_r [6];
    logic [2:0]  mux_r [6];
    logic [31:0] frc_r;
    logic [31:0] cmp_r [2];
    logic [1:0]  tog_r;
    logic [`DIV_W-1:0] div_r;
    logic [`DIV_W-1:0] div_mask;
    logic [5:0]  pin_s1_r;
    logic [5:0]  pin_s2_r;
    logic        noise_filter_clock_s1_r;
    logic        noise_filter_clock_s2_r;
    logic        noise_filter_clock_s3_r;
    logic        filt_tick;
    logic        active;
    logic        tick;
    logic        wr_ctrl;
    logic        wr_frc;
    logic [1:0]  cmp_hit;
    logic [31:0] cap_val [6];
    logic [5:0]  cap_fire;
    logic [31:0] rdata_nxt;

    // write decode
    assign wr_ctrl = clk_en && wr && addr == `OFS_CTRL;
    assign wr_frc  = clk_en && wr && addr == `OFS_FRC;

    // block runs only when turned on and not asleep
    assign active = turn_on_r && !sleep_en;

    // pins and filter clock pass two flops first
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pin_s1_r  <= 6'h00;
            pin_s2_r  <= 6'h00;
            noise_filter_clock_s1_r <= 1'b0;
            noise_filter_clock_s2_r <= 1'b0;
            noise_filter_clock_s3_r <= 1'b0;
        end else if (clk_en) begin
            pin_s1_r  <= capture_input_pin;
            pin_s2_r  <= pin_s1_r;
            noise_filter_clock_s1_r <= noise_filter_clock;
            noise_filter_clock_s2_r <= noise_filter_clock_s1_r;
            noise_filter_clock_s3_r <= noise_filter_clock_s2_r;
        end
    end

    assign filt_tick = noise_filter_clock_s2_r & ~noise_filter_clock_s3_r;

    // clock divider: tick every 2**code cycles
    assign div_mask = `DIV_W'((8'h01 << tcs_r) - 8'h01);
    assign tick     = clk_en && active && ((div_r & div_mask) == div_mask);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_r <= '0;
        end else if (clk_en && active) begin
            div_r <= div_r + `DIV_W'(1);
        end
    end

    // control register fields
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            turn_on_r <= 1'b0;
            tcs_r     <= 3'h0;
            cmp_en_r  <= 2'h0;
        end else if (wr_ctrl) begin
            turn_on_r <= wdata[`BIT_TURN_ON];
            tcs_r     <= wdata[`BIT_TCS_LO +: 3];
            cmp_en_r  <= wdata[`BIT_CMP_EN0 +: 2];
        end
    end

    // capture configuration and routing selector
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 6; i++) begin
                cap_cfg_r[i] <= '{bypass: 1'b0, edge_mode: edge_type'(`RST_EDGE)};
                mux_r[i]     <= 3'(`RST_MUX >> (i * `MUX_FIELD_W));
            end
        end else if (clk_en && wr) begin
            for (int i = 0; i < 6; i++) begin
                if (addr == ((i < 4) ? `OFS_CAP_CTL0 : `OFS_CAP_CTL1)) begin
                    cap_cfg_r[i] <= wdata[(i % 4) * `CAP_FIELD_W +: 3];
                end
                if (addr == `OFS_MUX) begin
                    mux_r[i] <= wdata[i * `MUX_FIELD_W +: 3];
                end
            end
        end
    end

    // compare registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cmp_r[0] <= 32'h0000_0000;
            cmp_r[1] <= 32'h0000_0000;
        end else if (clk_en && wr) begin
            if (addr == `OFS_CMP0) cmp_r[0] <= wdata;
            if (addr == `OFS_CMP1) cmp_r[1] <= wdata;
        end
    end

    // free-running counter, held while inactive
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            frc_r <= 32'h0000_0000;
        end else if (wr_frc) begin
            frc_r <= wdata;
        end else if (tick) begin
            frc_r <= frc_r + 32'h0000_0001;
        end
    end

    // match is taken on the step that makes counter equal compare
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cmp_hit[i] = tick && !wr_frc && cmp_en_r[i]
                         && (frc_r + 32'h0000_0001 == cmp_r[i]);
        end
    end

    // toggle flops: host set/clear first, else toggle on match
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tog_r <= 2'h0;
        end else if (clk_en) begin
            for (int i = 0; i < 2; i++) begin
                if (wr_ctrl && wdata[`BIT_SET0 - i]) begin
                    tog_r[i] <= 1'b1;
                end else if (wr_ctrl && wdata[`BIT_CLR0 - i]) begin
                    tog_r[i] <= 1'b0;
                end else if (cmp_hit[i]) begin
                    tog_r[i] <= ~tog_r[i];
                end
            end
        end
    end

    assign compare_output_pin_0 = tog_r[0];
    assign compare_output_pin_1 = tog_r[1];

    // six capture channels, each fed from its routed pin
    for (genvar g = 0; g < 6; g++) begin : g_cap
        capture_channel u_chan (
            .mclk      (mclk),
            .rst       (rst),
            .clk_en    (clk_en),
            .active    (active),
            .pin_sync  (pin_s2_r[mux_r[g]]),
            .filt_tick (filt_tick),
            .cfg       (cap_cfg_r[g]),
            .frc       (frc_r),
            .cap_r     (cap_val[g]),
            .fire_r    (cap_fire[g])
        );
    end

    // event pulses to the aggregator
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            events_r <= '0;
        end else if (clk_en) begin
            events_r.ovf <= tick && !wr_frc && frc_r == 32'hFFFF_FFFF;
            events_r.cap <= cap_fire;
            events_r.cmp <= cmp_hit;
        end
    end

    // low power handshake
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            low_power_ack_r <= 1'b0;
        end else if (clk_en) begin
            low_power_ack_r <= low_power_req && !active;
        end
    end

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (addr)
            `OFS_CTRL: begin
                rdata_nxt[`BIT_TURN_ON]       = turn_on_r;
                rdata_nxt[`BIT_TCS_LO +: 3]   = tcs_r;
                rdata_nxt[`BIT_CMP_EN0 +: 2]  = cmp_en_r;
                rdata_nxt[`BIT_SET0]          = tog_r[0];
                rdata_nxt[`BIT_SET0 - 1]      = tog_r[1];
                rdata_nxt[`BIT_CLR0]          = tog_r[0];
                rdata_nxt[`BIT_CLR0 - 1]      = tog_r[1];
            end
            `OFS_CAP_CTL0: begin
                for (int i = 0; i < 4; i++) begin
                    rdata_nxt[i * `CAP_FIELD_W +: 3] = cap_cfg_r[i];
                end
            end
            `OFS_CAP_CTL1: begin
                rdata_nxt[0 +: 3]            = cap_cfg_r[4];
                rdata_nxt[`CAP_FIELD_W +: 3] = cap_cfg_r[5];
            end
            `OFS_FRC:  rdata_nxt = frc_r;
            `OFS_CMP0: rdata_nxt = cmp_r[0];
            `OFS_CMP1: rdata_nxt = cmp_r[1];
            `OFS_MUX: begin
                for (int i = 0; i < 6; i++) begin
                    rdata_nxt[i * `MUX_FIELD_W +: 3] = mux_r[i];
                end
            end
            default: begin
                for (int i = 0; i < 6; i++) begin
                    if (addr == `OFS_CAP0 + 8'(i * 4)) rdata_nxt = cap_val[i];
                end
            end
        endcase
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (clk_en) begin
            rdata_r <= rd ? rdata_nxt : 32'h0000_0000;
        end
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_wrap_event: assert property (
        tick && !wr_frc && frc_r == 32'hFFFF_FFFF |=> events_r.ovf && frc_r == 32'h0)
        else $error("counter wrap without event");
    a_count_step: assert property (tick && !wr_frc |=> frc_r == $past(frc_r) + 32'h1)
        else $error("counter did not step by one");
    a_half_rate: assert property (
        tcs_r == 3'h1 && tick ##1 tcs_r == 3'h1 |-> !tick)
        else $error("divide by two ticked twice");
    a_full_rate: assert property (tcs_r == 3'h0 && active && clk_en |-> tick)
        else $error("divide by one missed a tick");
    a_sleep_hold: assert property (clk_en && sleep_en && !wr_frc |=> $stable(frc_r))
        else $error("counter moved while asleep");
    a_cmp_toggle: assert property (
        clk_en && cmp_hit[0] && !wr_ctrl |=> tog_r[0] != $past(tog_r[0]) && events_r.cmp[0])
        else $error("match did not toggle");
    a_cmp_disabled: assert property (clk_en && !cmp_en_r[1] |=> !events_r.cmp[1])
        else $error("disabled compare raised event");
    a_set_force: assert property (wr_ctrl && wdata[`BIT_SET0 - 1] |=> tog_r[1])
        else $error("set did not force one");
    a_clear_force: assert property (
        wr_ctrl && wdata[`BIT_CLR0] && !wdata[`BIT_SET0] |=> !tog_r[0])
        else $error("clear did not force zero");
    a_read_state: assert property (
        clk_en && rd && addr == `OFS_CTRL |=> rdata_r[`BIT_SET0] == $past(tog_r[0]))
        else $error("set bit read wrong state");
    a_lp_refused: assert property (clk_en && active |=> !low_power_ack_r)
        else $error("low power accepted while active");

    c_wrap: cover property (events_r.ovf);
    c_compare: cover property (events_r.cmp[0] ##[1:50] events_r.cmp[0]);
    c_capture: cover property (events_r.cap[5]);
    c_lp_ack: cover property (low_power_ack_r);

endmodule // input_capture_compare_timer
`default_nettype wire

// ---- testbench/input_capture_compare_timer_tb.sv ----
// self-checking bench of the capture/compare timer
`timescale 1ns/1ps
`default_nettype none
`include "icct_defines.svh"

module input_capture_compare_timer_tb;
    import icct_pkg::*;
    logic        mclk, rst, clk_en, wr, rd, sleep_en, low_power_req, low_power_ack_r;
    logic        pin0, pin1, filt_run, filt_clk;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata_r, v, w;
    logic [5:0]  lvl, pins;
    event_type   events_r;
    int          ev_cnt [9];
    int          load_edges, fails, tests_run, cycles;

    input_capture_compare_timer u_input_capture_compare_timer (
        .mclk(mclk), .rst(rst), .clk_en(clk_en), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata_r(rdata_r), .capture_input_pin(pins), .noise_filter_clock(filt_clk),
        .sleep_en(sleep_en), .low_power_req(low_power_req), .low_power_ack_r(low_power_ack_r),
        .compare_output_pin_0(pin0), .compare_output_pin_1(pin1), .events_r(events_r));

    pin_source_model u_pin_source_model (
        .mclk(mclk), .rst(rst), .level_req(lvl), .filt_run(filt_run), .cmp_pin_0(pin0),
        .cmp_pin_1(pin1), .pins(pins), .filt_clk(filt_clk), .load_edges(load_edges));

    always #5 mclk = ~mclk;

    // event pulse counters and hang guard
    always @(posedge mclk) begin
        for (int i = 0; i < 9; i++) begin
            ev_cnt[i] += int'(events_r[i]);
        end
        cycles++;
        if (cycles == 20000) begin
            fails++;
            conclude();
        end
    end

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
        d = rdata_r;
    endtask

    task automatic t_reset();
        rd_reg(`OFS_CTRL, v);
        check(v, 32'h0000_0000);
        rd_reg(`OFS_MUX, v);
        check(v, 32'h0054_3210);
        rd_reg(`OFS_FRC, v);
        check(v, 32'h0000_0000);
        rd_reg(`OFS_CAP0, v);
        check(v, 32'h0000_0000);
        rd_reg(8'h34, v);
        check(v, 32'h0000_0000);
        check({30'h0, pin1, pin0}, 32'h0000_0000);
    endtask

    // counter advance over 256 cycles for every clock select code
    task automatic t_divide();
        for (int c = 0; c < 8; c++) begin
            wr_reg(`OFS_CTRL, 32'h1 | (c << 4));
            rd_reg(`OFS_FRC, v);
            waitc(253);
            rd_reg(`OFS_FRC, w);
            check(w - v, 32'(256 >> c));
        end
    endtask

    task automatic t_overflow();
        int e;
        wr_reg(`OFS_CTRL, 32'h0000_0000);
        wr_reg(`OFS_FRC, 32'hFFFF_FFFE);
        e = ev_cnt[0];
        wr_reg(`OFS_CTRL, 32'h0000_0001);
        waitc(10);
        check(32'(ev_cnt[0] - e), 32'h1);
        rd_reg(`OFS_FRC, v);
        check({31'h0, v < 32'h10}, 32'h1);
        // clock enable low for ten edges freezes the counter
        rd_reg(`OFS_FRC, v);
        clk_en <= 1'b0;
        waitc(10);
        clk_en <= 1'b1;
        rd_reg(`OFS_FRC, w);
        check(w - v, 32'h0000_0003);
    endtask

    task automatic t_compare();
        int e7, e8, le;
        logic p0, p1;
        wr_reg(`OFS_CTRL, 32'h0000_0000);
        wr_reg(`OFS_FRC, 32'h0000_0100);
        wr_reg(`OFS_CMP0, 32'h0000_0105);
        wr_reg(`OFS_CMP1, 32'h0000_010A);
        e7 = ev_cnt[7];
        e8 = ev_cnt[8];
        le = load_edges;
        p0 = pin0;
        p1 = pin1;
        wr_reg(`OFS_CTRL, 32'h0000_0301);
        waitc(20);
        check(32'(ev_cnt[7] - e7), 32'h1);
        check(32'(ev_cnt[8] - e8), 32'h1);
        check({30'h0, pin1, pin0}, {30'h0, ~p1, ~p0});
        check(32'(load_edges - le), 32'h2);
        wr_reg(`OFS_CTRL, 32'h0000_0000);
        wr_reg(`OFS_FRC, 32'h0000_0100);
        wr_reg(`OFS_CTRL, 32'h0000_0101);
        waitc(20);
        check(32'(ev_cnt[7] - e7), 32'h2);
        check(32'(ev_cnt[8] - e8), 32'h1);
        check({30'h0, pin1, pin0}, {30'h0, ~p1, p0});
    endtask

    task automatic t_force();
        wr_reg(`OFS_CTRL, 32'h0300_0000);
        check({30'h0, pin1, pin0}, 32'h0);
        wr_reg(`OFS_CTRL, 32'h0002_0000);
        check({30'h0, pin1, pin0}, 32'h1);
        rd_reg(`OFS_CTRL, v);
        check(v, 32'h0202_0000);
        wr_reg(`OFS_CTRL, 32'h0101_0000);
        check({30'h0, pin1, pin0}, 32'h3);
        wr_reg(`OFS_CTRL, 32'h0200_0000);
        check({30'h0, pin1, pin0}, 32'h2);
        wr_reg(`OFS_CTRL, 32'h0000_0000);
        check({30'h0, pin1, pin0}, 32'h2);
    endtask

    task automatic t_sleep();
        wr_reg(`OFS_CTRL, 32'h0000_0001);
        low_power_req <= 1'b1;
        waitc(3);
        check({31'h0, low_power_ack_r}, 32'h0);
        sleep_en <= 1'b1;
        waitc(3);
        check({31'h0, low_power_ack_r}, 32'h1);
        rd_reg(`OFS_FRC, v);
        waitc(20);
        rd_reg(`OFS_FRC, w);
        check(w, v);
        sleep_en <= 1'b0;
        waitc(10);
        rd_reg(`OFS_FRC, w);
        check({31'h0, w > v && w < v + 32'd20}, 32'h1);
        wr_reg(`OFS_CTRL, 32'h0000_0000);
        waitc(3);
        check({31'h0, low_power_ack_r}, 32'h1);
        low_power_req <= 1'b0;
        waitc(3);
        check({31'h0, low_power_ack_r}, 32'h0);
    endtask

    // cap0 rise+bypass, cap1 fall filtered, cap2 both, cap3/4 off, cap5 rise fed by pin 0
    task automatic t_capture();
        int e [9];
        wr_reg(`OFS_CTRL, 32'h0000_0000);
        wr_reg(`OFS_CAP_CTL0, 32'h0306_0005);
        wr_reg(`OFS_CAP_CTL1, 32'h0000_0503);
        wr_reg(`OFS_MUX, 32'h0004_3210);
        wr_reg(`OFS_FRC, 32'h0000_1000);
        wr_reg(`OFS_CTRL, 32'h0000_0071);
        filt_run <= 1'b1;
        e = ev_cnt;
        lvl[0] <= 1'b1;
        waitc(20);
        check(32'(ev_cnt[1] - e[1]), 32'h1);
        check(32'(ev_cnt[6] - e[6]), 32'h1);
        rd_reg(`OFS_CAP0, v);
        check({31'h0, v == 32'h1000 || v == 32'h1001}, 32'h1);
        rd_reg(`OFS_CAP5, w);
        check(w, v);
        lvl[2] <= 1'b1;
        waitc(20);
        lvl[2] <= 1'b0;
        lvl[3] <= 1'b1;
        waitc(20);
        check(32'(ev_cnt[3] - e[3]), 32'h2);
        check(32'(ev_cnt[4] - e[4]), 32'h0);
        lvl[1] <= 1'b1;
        waitc(80);
        lvl[1] <= 1'b0;
        waitc(10);
        lvl[1] <= 1'b1;
        waitc(80);
        check(32'(ev_cnt[2] - e[2]), 32'h0);
        lvl[1] <= 1'b0;
        waitc(80);
        check(32'(ev_cnt[2] - e[2]), 32'h1);
        wr_reg(`OFS_CAP0, 32'h1234_5678);
        rd_reg(`OFS_CAP0, w);
        check(w, v);
        lvl[0] <= 1'b0;
        waitc(300);
        lvl[0] <= 1'b1;
        waitc(20);
        rd_reg(`OFS_CAP0, w);
        check({31'h0, w >= v + 32'd4 && w <= v + 32'd5}, 32'h1);
        check(32'(ev_cnt[1] - e[1]), 32'h2);
    endtask

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        clk_en = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        sleep_en = 1'b0;
        low_power_req = 1'b0;
        filt_run = 1'b0;
        lvl = 6'h00;
        fails = 0;
        tests_run = 0;
        cycles = 0;
        foreach (ev_cnt[i]) ev_cnt[i] = 0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        t_reset();
        t_divide();
        t_overflow();
        t_compare();
        t_force();
        t_sleep();
        t_capture();
        conclude();
    end
endmodule // input_capture_compare_timer_tb

`default_nettype wire

// ---- testbench/pin_source_model.sv ----
// far-side model: capture pin sources, filter clock and compare output loads
`timescale 1ns/1ps
`default_nettype none

module pin_source_model (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic [5:0] level_req,
    input  wire logic       filt_run,
    input  wire logic       cmp_pin_0,
    input  wire logic       cmp_pin_1,
    output logic      [5:0] pins,
    output logic            filt_clk,
    output int              load_edges
);
    logic [1:0] div_r;
    logic [1:0] last_r;

    // pins follow the requested levels one edge later, low in reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pins <= 6'h00;
        end else begin
            pins <= level_req;
        end
    end

    // filter clock: one rising edge per 8 cycles, parked low when stopped
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div_r    <= 2'h0;
            filt_clk <= 1'b0;
        end else if (filt_run) begin
            div_r <= div_r + 2'h1;
            if (div_r == 2'h3) begin
                filt_clk <= ~filt_clk;
            end
        end else begin
            filt_clk <= 1'b0;
        end
    end

    // load counts every level change seen on the compare outputs
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            last_r     <= 2'h0;
            load_edges <= 0;
        end else begin
            last_r     <= {cmp_pin_1, cmp_pin_0};
            load_edges <= load_edges + int'(last_r[0] ^ cmp_pin_0) + int'(last_r[1] ^ cmp_pin_1);
        end
    end
endmodule // pin_source_model

`default_nettype wire
